// ---- verilog/conv_pkg.sv ----
// constants and types shared by the converter control and the core-side end
package conv_pkg;
  // ---------------------------------------------------------------------------
  // result format
  // ---------------------------------------------------------------------------
  localparam int unsigned RESULT_W       = 10;          // converter code width
  localparam int unsigned BYTE_W         = 8;           // result byte width
  localparam logic [9:0]  CODE_MIN_SE    = 10'h000;     // single-ended ground code
  localparam logic [9:0]  CODE_MAX_SE    = 10'h3ff;     // single-ended full scale (1023)
  localparam logic [9:0]  CODE_MIN_DIFF  = 10'h200;     // differential most negative (-512)
  localparam logic [9:0]  CODE_MAX_DIFF  = 10'h1ff;     // differential most positive (+511)
  localparam int unsigned SIGN_POS       = 9;           // sign bit position in code
  // ---------------------------------------------------------------------------
  // timing, in converter clock cycles
  // ---------------------------------------------------------------------------
  localparam logic [4:0]  CYC_NORMAL     = 5'h0d;       // normal conversion, 13 cycles
  localparam logic [4:0]  CYC_FIRST      = 5'h19;       // first after enable, 25 cycles
  // ---------------------------------------------------------------------------
  // sleep modes reported by the sleep controller
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SLEEP_IDLE       = 3'h0,
    SLEEP_NOISE_RED  = 3'h1,
    SLEEP_POWER_DOWN = 3'h2,
    SLEEP_STANDBY    = 3'h3
  } sleep_mode_t;
  // reset values
  localparam logic        CTRL_RESET     = 1'b0;        // start and flag bits clear
  localparam logic [7:0]  BYTE_RESET     = 8'h00;       // result bytes clear
endpackage

// ---- verilog/conv_if.sv ----
// link between the converter control and the processor core with its sleep controller
`timescale 1ns/10ps
interface conv_if;
  logic                    converter_enable;     // software enable level
  logic                    auto_trigger_enable;  // software auto trigger level
  logic                    irq_enable;           // completion interrupt enable
  logic                    left_adjust_result;   // result alignment select
  logic                    differential;         // channel is a differential pair
  logic                    start_write;          // pulse: software writes one to start
  logic                    flag_clear_write;     // pulse: software writes one to the flag
  logic                    vector_ack;           // pulse: interrupt vector executes
  logic                    sleep_halted;         // pulse: core halted after sleep command
  conv_pkg::sleep_mode_t   sleep_mode;           // mode of that sleep entry
  logic                    conv_clk_en;          // pulse: converter clock edge
  logic [9:0]              sample_code;          // code produced by the analog core
  logic                    start_conversion_bit; // busy / start bit read back
  logic                    conversion_done_flag; // completion flag read back
  logic [7:0]              result_high_byte;     // high result byte
  logic [7:0]              result_low_byte;      // low result byte
  logic                    conv_irq;             // interrupt request / wake

  modport device (
    input  converter_enable, auto_trigger_enable, irq_enable, left_adjust_result,
    input  differential, start_write, flag_clear_write, vector_ack, sleep_halted,
    input  sleep_mode, conv_clk_en, sample_code,
    output start_conversion_bit, conversion_done_flag, result_high_byte,
    output result_low_byte, conv_irq
  );
  modport core (
    output converter_enable, auto_trigger_enable, irq_enable, left_adjust_result,
    output differential, start_write, flag_clear_write, vector_ack, sleep_halted,
    output sleep_mode, conv_clk_en, sample_code,
    input  start_conversion_bit, conversion_done_flag, result_high_byte,
    input  result_low_byte, conv_irq
  );
endinterface

// ---- verilog/conv_ctrl.sv ----
// converter control: sleep-started conversion, completion flag and result format
// Operation
// - sleep entry starts single conversion when idle
// - software prepares single mode, enabled, irq
// - completion interrupt wakes core, runs service
// - completion request raised even after other wake
// - other sleep modes leave enable untouched
// - software should disable before deep sleep
// - software re-enables before differential after sleep
// - digital pins quiet during conversion
// - result readable once flag is high
// - single-ended unsigned ten-bit code
// - differential two's complement ten-bit code
// - result top bit is differential sign
// - left adjust splits bytes nine-two / one-zero
// - completion clears start, writes result, sets flag
// - thirteen cycles normal, twenty-five first
// - flag clears on vector or write one
// - left adjust rearranges bytes immediately
`timescale 1ns/10ps
module conv_ctrl (
  input  wire logic clk,
  input  wire logic arst_n,
  conv_if.device    link
);
  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_CONVERT} conv_state_t;
  conv_state_t state_q, state_d;        // conversion sequencer
  logic [4:0]  cnt_q, cnt_d;            // converter clocks still to run
  logic        first_q, first_d;        // next conversion is the first one
  logic        start_q, start_d;        // start / busy bit
  logic        flag_q, flag_d;          // completion flag
  logic [9:0]  code_q, code_d;          // stored conversion code

  // ---------------------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------------------
  // sleep entry into idle or noise reduction qualifies an automatic start
  wire logic sleep_ok   = link.sleep_halted &&
                          (link.sleep_mode == conv_pkg::SLEEP_IDLE ||
                           link.sleep_mode == conv_pkg::SLEEP_NOISE_RED);
  // single mode, enabled and idle; other sleep modes change nothing
  wire logic sleep_go   = sleep_ok && link.converter_enable &&
                          !link.auto_trigger_enable && !start_q;
  // start bit set by software write or by the sleep start
  wire logic start_set  = (link.start_write && link.converter_enable) || sleep_go;
  // converter clock edge that begins a pending conversion
  wire logic begin_conv = (state_q == ST_IDLE) && start_q && link.conv_clk_en;
  // last converter clock of a running conversion
  wire logic done_conv  = (state_q == ST_CONVERT) && link.conv_clk_en &&
                          (cnt_q == 5'h01);
  // length of the conversion being started
  wire logic [4:0] conv_len = first_q ? conv_pkg::CYC_FIRST : conv_pkg::CYC_NORMAL;

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  // sequencer and flags
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    first_d = first_q;
    start_d = start_q;
    flag_d  = flag_q;
    code_d  = code_q;
    if (link.vector_ack || link.flag_clear_write) begin
      flag_d = 1'b0;
    end
    if (start_set) begin
      start_d = 1'b1;
    end
    // disabling rearms the long first conversion
    if (!link.converter_enable && state_q == ST_IDLE) begin
      first_d = 1'b1;
    end
    case (state_q)
      ST_IDLE: begin
        if (begin_conv) begin
          state_d = ST_CONVERT;
          cnt_d   = conv_len;
          first_d = 1'b0;
        end
      end
      ST_CONVERT: begin
        if (link.conv_clk_en) begin
          cnt_d = cnt_q - 5'h01;
        end
        if (done_conv) begin
          state_d = ST_IDLE;
          start_d = 1'b0;
          flag_d  = 1'b1;                // set beats clear
          code_d  = link.sample_code;    // code taken as is
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  // control state clears on reset; first_q sets for a long first conversion
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      cnt_q   <= 5'h00;
      first_q <= 1'b1;
      start_q <= conv_pkg::CTRL_RESET;
      flag_q  <= conv_pkg::CTRL_RESET;
      code_q  <= 10'h000;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      first_q <= first_d;
      start_q <= start_d;
      flag_q  <= flag_d;
      code_q  <= code_d;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign link.start_conversion_bit = start_q;
  assign link.conversion_done_flag = flag_q;
  // alignment follows the select with no delay
  assign link.result_high_byte = link.left_adjust_result ? code_q[9:2]
                                 : {6'h00, code_q[9:8]};
  assign link.result_low_byte  = link.left_adjust_result ? {code_q[1:0], 6'h00}
                                 : code_q[7:0];
  // interrupt request, also the wake from idle and noise reduction
  assign link.conv_irq = flag_q && link.irq_enable;
endmodule

// ---- verilog/conv_core.sv ----
// core-side end: software register bits, sleep entry and converter clock strobe
`timescale 1ns/10ps
module conv_core (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  conv_if.core                       link,
  input  wire logic                  sw_enable,      // requested enable level
  input  wire logic                  sw_auto,        // requested auto trigger level
  input  wire logic                  sw_irq_enable,  // requested interrupt enable
  input  wire logic                  sw_left_adjust, // requested alignment
  input  wire logic                  sw_differential,// differential channel chosen
  input  wire logic                  sw_start,       // pulse: write one to start
  input  wire logic                  sw_flag_clear,  // pulse: write one to flag
  input  wire logic                  sleep_cmd,      // pulse: sleep instruction
  input  wire conv_pkg::sleep_mode_t sleep_sel,      // mode for that instruction
  input  wire logic                  other_wake,     // another interrupt wakes core
  input  wire logic [3:0]            clk_div,        // converter clock divide minus one
  input  wire logic [9:0]            analog_code,    // code from analog core
  output logic                       asleep,         // core halted
  output logic                       isr_run,        // pulse: completion vector runs
  output logic [7:0]                 rd_high,        // high result byte read
  output logic [7:0]                 rd_low          // low result byte read
);
  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  logic       asleep_q;       // core halted
  logic       halt_q;         // one-cycle halted strobe
  logic       isr_q;          // vector runs this cycle
  logic [3:0] div_q;          // converter clock divider
  logic [7:0] hi_q, lo_q;     // captured result bytes

  // vector runs when request is up and the core is awake
  wire logic take_irq = link.conv_irq && !asleep_q && !isr_q;
  // software keeps single mode and enable during sleep start
  assign link.converter_enable    = sw_enable;
  assign link.auto_trigger_enable = sw_auto;
  assign link.irq_enable          = sw_irq_enable;
  assign link.left_adjust_result  = sw_left_adjust;
  assign link.differential        = sw_differential;
  assign link.start_write         = sw_start;
  assign link.flag_clear_write    = sw_flag_clear;
  assign link.vector_ack          = isr_q;
  assign link.sleep_halted        = halt_q;
  assign link.sleep_mode          = sleep_sel;
  assign link.conv_clk_en         = (div_q == clk_div);
  assign link.sample_code         = analog_code;
  assign asleep                   = asleep_q;
  assign isr_run                  = isr_q;
  assign rd_high                  = hi_q;
  assign rd_low                   = lo_q;

  // ---------------------------------------------------------------------------
  // sleep, wake and vector
  // ---------------------------------------------------------------------------
  // any request or other interrupt wakes the core
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      asleep_q <= 1'b0;
      halt_q   <= 1'b0;
      isr_q    <= 1'b0;
      div_q    <= 4'h0;
      hi_q     <= conv_pkg::BYTE_RESET;
      lo_q     <= conv_pkg::BYTE_RESET;
    end else begin
      halt_q   <= sleep_cmd && !asleep_q;
      asleep_q <= asleep_q ? !(link.conv_irq || other_wake) : sleep_cmd;
      isr_q    <= take_irq;
      div_q    <= (div_q == clk_div) ? 4'h0 : div_q + 4'h1;
      if (link.conversion_done_flag) begin
        hi_q <= link.result_high_byte;
        lo_q <= link.result_low_byte;
      end
    end
  end
endmodule

// ---- verif/conv_props.sv ----
// concurrent checks on the link between the converter control and the core-side end
`timescale 1ns/10ps
module conv_props (
  input wire logic                  clk,
  input wire logic                  arst_n,
  input wire logic                  converter_enable,
  input wire logic                  auto_trigger_enable,
  input wire logic                  irq_enable,
  input wire logic                  left_adjust_result,
  input wire logic                  start_write,
  input wire logic                  flag_clear_write,
  input wire logic                  vector_ack,
  input wire logic                  sleep_halted,
  input wire conv_pkg::sleep_mode_t sleep_mode,
  input wire logic                  conv_clk_en,
  input wire logic                  start_conversion_bit,
  input wire logic                  conversion_done_flag,
  input wire logic [7:0]            result_high_byte,
  input wire logic [7:0]            result_low_byte,
  input wire logic                  conv_irq
);
  // ---------------------------------------------------------------------------
  // helper logic
  // ---------------------------------------------------------------------------
  logic [4:0] pulse_q;    // converter clock pulses seen while busy
  wire  [9:0] code_seen = left_adjust_result ? {result_high_byte, result_low_byte[7:6]}
                                             : {result_high_byte[1:0], result_low_byte};
  wire        shallow   = (sleep_mode == conv_pkg::SLEEP_IDLE) ||
                          (sleep_mode == conv_pkg::SLEEP_NOISE_RED);  // quiet sleep modes
  // count pulses of one conversion, begin pulse included, cleared whenever idle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) pulse_q <= 5'h00;
    else if (!start_conversion_bit) pulse_q <= 5'h00;
    else if (conv_clk_en) pulse_q <= pulse_q + 5'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  a_irq_follows_flag: assert property (conv_irq == (conversion_done_flag && irq_enable))
    else $error("interrupt request differs from flag and enable");
  a_done_ends_start: assert property ($rose(conversion_done_flag) |-> $fell(start_conversion_bit))
    else $error("start bit not cleared with completion");
  a_sleep_starts: assert property (sleep_halted && shallow && converter_enable &&
    !auto_trigger_enable && !start_conversion_bit |=> start_conversion_bit)
    else $error("sleep entry did not start a conversion");
  a_deep_refused: assert property (sleep_halted && !shallow && !start_write &&
    !start_conversion_bit |=> !start_conversion_bit)
    else $error("deep sleep started a conversion");
  a_flag_clears: assert property (conversion_done_flag && vector_ack &&
    !start_conversion_bit |=> !conversion_done_flag)
    else $error("flag not cleared by vector");
  a_flag_stands: assert property (conversion_done_flag && !vector_ack &&
    !flag_clear_write |=> conversion_done_flag)
    else $error("flag dropped without clear");
  a_left_layout: assert property (left_adjust_result |-> result_low_byte[5:0] == 6'h00)
    else $error("left adjusted low byte not padded");
  a_right_layout: assert property (!left_adjust_result |-> result_high_byte[7:2] == 6'h00)
    else $error("right adjusted high byte not padded");
  a_adjust_now: assert property ($changed(left_adjust_result) &&
    !$fell(start_conversion_bit) |-> code_seen == $past(code_seen))
    else $error("alignment change altered the code");
  a_bytes_hold: assert property (!$past(start_conversion_bit) &&
    $stable(left_adjust_result) |-> $stable(result_high_byte) && $stable(result_low_byte))
    else $error("result bytes moved without a conversion");
  a_pulse_count: assert property ($fell(start_conversion_bit) |->
    (pulse_q == conv_pkg::CYC_NORMAL + 5'h01) || (pulse_q == conv_pkg::CYC_FIRST + 5'h01))
    else $error("conversion length out of range");
endmodule

// ---- verif/tb.sv ----
// self-checking bench for the converter control joined to its core-side end
`timescale 1ns/10ps
module tb;
  // ---------------------------------------------------------------------------
  // clock, reset and core-side stimulus
  // ---------------------------------------------------------------------------
  logic                  clk = 1'b0;             // 125 MHz system clock
  logic                  arst_n = 1'b0;          // asynchronous reset, low active
  logic                  sw_enable = 1'b0, sw_auto = 1'b0, sw_irq_enable = 1'b0;
  logic                  sw_left_adjust = 1'b0, sw_differential = 1'b0;
  logic                  sw_start = 1'b0, sw_flag_clear = 1'b0, sleep_cmd = 1'b0;
  logic                  other_wake = 1'b0;      // foreign wake source
  conv_pkg::sleep_mode_t sleep_sel = conv_pkg::SLEEP_IDLE;
  logic [3:0]            clk_div = 4'h1;         // converter clock at half rate
  logic [9:0]            analog_code = 10'h3ff;  // single-ended full scale
  logic                  asleep, isr_run;        // core state seen back
  logic [7:0]            rd_high, rd_low;        // bytes read by the core
  int                    bad_count = 0, checks = 0;
  int                    isr_seen = 0;           // completion vectors seen
  always #4 clk = ~clk;
  // count vector pulses away from the edge that launches them
  always @(negedge clk) begin
    if (isr_run === 1'b1) begin
      isr_seen++;
    end
  end
  conv_if link ();
  conv_ctrl i_conv_ctrl (.clk(clk), .arst_n(arst_n), .link(link));
  conv_core i_conv_core (.clk(clk), .arst_n(arst_n), .link(link), .sw_enable(sw_enable),
    .sw_auto(sw_auto), .sw_irq_enable(sw_irq_enable), .sw_left_adjust(sw_left_adjust),
    .sw_differential(sw_differential), .sw_start(sw_start), .sw_flag_clear(sw_flag_clear),
    .sleep_cmd(sleep_cmd), .sleep_sel(sleep_sel), .other_wake(other_wake), .clk_div(clk_div),
    .analog_code(analog_code), .asleep(asleep), .isr_run(isr_run), .rd_high(rd_high),
    .rd_low(rd_low));
  conv_props i_conv_props (.clk(clk), .arst_n(arst_n),
    .converter_enable(link.converter_enable), .auto_trigger_enable(link.auto_trigger_enable),
    .irq_enable(link.irq_enable), .left_adjust_result(link.left_adjust_result),
    .start_write(link.start_write), .flag_clear_write(link.flag_clear_write),
    .vector_ack(link.vector_ack), .sleep_halted(link.sleep_halted),
    .sleep_mode(link.sleep_mode), .conv_clk_en(link.conv_clk_en),
    .start_conversion_bit(link.start_conversion_bit),
    .conversion_done_flag(link.conversion_done_flag),
    .result_high_byte(link.result_high_byte), .result_low_byte(link.result_low_byte),
    .conv_irq(link.conv_irq));
  // ---------------------------------------------------------------------------
  // compare, access and closing tasks
  // ---------------------------------------------------------------------------
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_byte(what, {7'h00, exp}, {7'h00, got});
  endtask
  // sleep instruction with its mode, one cycle long
  task automatic go_sleep(input conv_pkg::sleep_mode_t m);
    @(posedge clk);
    sleep_sel <= m;
    sleep_cmd <= 1'b1;
    @(posedge clk);
    sleep_cmd <= 1'b0;
  endtask
  // bounded wait for completion, then a check that the flag stands
  task automatic wait_flag();
    int n;
    n = 0;
    while (link.conversion_done_flag !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk_bit("done flag", 1'b1, link.conversion_done_flag);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    sw_enable <= 1'b1;
    sw_irq_enable <= 1'b1;
    go_sleep(conv_pkg::SLEEP_IDLE);
    wait_flag();
    chk_byte("high byte", 8'h03, link.result_high_byte);
    chk_byte("low byte", 8'hff, link.result_low_byte);
    repeat (4) @(negedge clk);
    chk_bit("flag after vector", 1'b0, link.conversion_done_flag);
    chk_bit("asleep", 1'b0, asleep);
    chk_byte("read high", 8'h03, rd_high);
    chk_byte("read low", 8'hff, rd_low);
    $display("test idle sleep conversion done");
    @(posedge clk);
    sw_left_adjust <= 1'b1;
    sw_differential <= 1'b1;
    analog_code <= 10'h270;
    go_sleep(conv_pkg::SLEEP_NOISE_RED);
    wait_flag();
    chk_byte("high byte", 8'h9c, link.result_high_byte);
    chk_byte("low byte", 8'h00, link.result_low_byte);
    chk_bit("sign bit", 1'b1, link.result_high_byte[7]);
    @(posedge clk);
    sw_left_adjust <= 1'b0;
    @(negedge clk);
    chk_byte("high byte", 8'h02, link.result_high_byte);
    chk_byte("low byte", 8'h70, link.result_low_byte);
    $display("test differential alignment done");
    for (int k = 2; k < 4; k++) begin
      go_sleep(conv_pkg::sleep_mode_t'(k));
      repeat (4) @(negedge clk);
      chk_bit("busy in deep sleep", 1'b0, link.start_conversion_bit);
      repeat (56) @(negedge clk);
      chk_bit("enable kept", 1'b1, link.converter_enable);
      chk_bit("still asleep", 1'b1, asleep);
      @(posedge clk);
      other_wake <= 1'b1;
      @(posedge clk);
      other_wake <= 1'b0;
    end
    sw_enable <= 1'b0;
    @(posedge clk);
    sw_enable <= 1'b1;
    $display("test deep sleep modes done");
    go_sleep(conv_pkg::SLEEP_IDLE);
    repeat (3) @(posedge clk);
    other_wake <= 1'b1;
    @(posedge clk);
    other_wake <= 1'b0;
    wait_flag();
    chk_bit("request after early wake", 1'b1, link.conv_irq);
    $display("test early wake done");
    repeat (4) @(posedge clk);
    sw_irq_enable <= 1'b0;
    sw_start <= 1'b1;
    @(posedge clk);
    sw_start <= 1'b0;
    wait_flag();
    chk_bit("masked request", 1'b0, link.conv_irq);
    repeat (3) @(negedge clk);
    chk_bit("flag stands", 1'b1, link.conversion_done_flag);
    @(posedge clk);
    sw_flag_clear <= 1'b1;
    @(posedge clk);
    sw_flag_clear <= 1'b0;
    repeat (3) @(negedge clk);
    chk_bit("flag after write one", 1'b0, link.conversion_done_flag);
    chk_byte("read high", 8'h02, rd_high);
    chk_byte("read low", 8'h70, rd_low);
    chk_byte("vector runs", 8'h03, isr_seen[7:0]);
    $display("test software start and clear done");
    results();
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    results();
  end
endmodule
